/* File: rtl/dmc_defines.vh */
// Constants for the DMA enable/status and channel 0 mode block.
// Assumes inclusion by the design files of this block only.
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define DMC_ADDR_STATUS     8'h30
`define DMC_ADDR_MODE       8'h31

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define DMC_ST_CH1_EN       7
`define DMC_ST_CH0_EN       6
`define DMC_ST_CH1_GUARD    5
`define DMC_ST_CH0_GUARD    4
`define DMC_ST_CH1_IE       3
`define DMC_ST_CH0_IE       2
`define DMC_ST_MASTER       0

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define DMC_MD_DST_HI       5
`define DMC_MD_DST_LO       4
`define DMC_MD_SRC_HI       3
`define DMC_MD_SRC_LO       2
`define DMC_MD_TIMING       1
`define DMC_MODE_MASK       8'h3e
`define DMC_MODE_RESET      8'h00

// ----------------------------------------
// Mode field encodings
// ----------------------------------------
`define DMC_AM_INC          2'h0
`define DMC_AM_DEC          2'h1
`define DMC_AM_FIX          2'h2
`define DMC_AM_IO           2'h3

`endif

/* File: rtl/dmc_mode_decode.v */
// Channel 0 mode decoder: address step and memory/I/O selection.
// Assumes a mode field value from the mode register.
`include "dmc_defines.vh"

module dmc_mode_decode (
  input  wire [1:0] mode_in,
  output wire       is_io_out,
  output wire       inc_out,
  output wire       dec_out
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign is_io_out = (mode_in == `DMC_AM_IO);
  assign inc_out   = (mode_in == `DMC_AM_INC);
  assign dec_out   = (mode_in == `DMC_AM_DEC);

endmodule // dmc_mode_decode

/* File: rtl/dmc_pace.v */
// Channel 0 pacing: decides each cycle whether a byte transfer may start.
// Assumes one transfer cycle per grant; the caller holds the bus between.
`include "dmc_defines.vh"

module dmc_pace (
  input  wire clk_in,
  input  wire rstn_in,
  input  wire active_in,
  input  wire io_mode_in,
  input  wire burst_in,
  input  wire request_in,
  input  wire xfer_in,
  output wire go_out,
  output wire bus_hold_out
);

  reg steal_gap_reg;
  reg steal_gap_next;

  // ----------------------------------------
  // Cycle-steal gap
  // ----------------------------------------
  // One CPU cycle follows each stolen transfer
  always @* begin
    steal_gap_next = 1'b0;
    if (active_in && !io_mode_in && !burst_in && xfer_in) begin
      steal_gap_next = 1'b1;
    end
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      steal_gap_reg <= 1'b0;
    end else begin
      steal_gap_reg <= steal_gap_next;
    end
  end

  // I/O uses the request; memory ignores it and uses timing bit
  assign go_out = active_in &&
                  (io_mode_in ? request_in
                              : (burst_in || !steal_gap_reg));

  // Burst keeps the bus until completion
  assign bus_hold_out = active_in && !io_mode_in && burst_in;

endmodule // dmc_pace

/* File: rtl/dmc_top.v */
// DMA enable/status and channel 0 mode registers with channel 0 pacing.
// Assumes a synchronous internal I/O bus: one-cycle write strobe, read
// data sampled the cycle after the read strobe. Byte counters live
// outside; they report reaching zero as one-cycle pulses.
`include "dmc_defines.vh"

module dmc_top (
  input  wire       CLK_IN,
  input  wire       RSTN_IN,
  input  wire [7:0] ADDR_IN,
  input  wire [7:0] WDATA_IN,
  input  wire       WR_IN,
  input  wire       RD_IN,
  input  wire       NMI_IN,
  input  wire       CH0_COUNT_ZERO_IN,
  input  wire       CH1_COUNT_ZERO_IN,
  input  wire       CH0_REQUEST_IN,
  input  wire       CH0_XFER_DONE_IN,
  output reg  [7:0] RDATA_OUT,
  output wire       CH0_ACTIVE_OUT,
  output wire       CH1_ACTIVE_OUT,
  output wire       CH0_GO_OUT,
  output wire       CH0_BUS_HOLD_OUT,
  output wire       CH0_IRQ_OUT,
  output wire       CH1_IRQ_OUT,
  output wire       CH0_SRC_IO_OUT,
  output wire       CH0_SRC_INC_OUT,
  output wire       CH0_SRC_DEC_OUT,
  output wire       CH0_DST_IO_OUT,
  output wire       CH0_DST_INC_OUT,
  output wire       CH0_DST_DEC_OUT,
  output wire       CH0_MODE_VALID_OUT
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg        ch0_enable_reg;
  reg        ch0_enable_next;
  reg        ch1_enable_reg;
  reg        ch1_enable_next;
  reg        ch0_done_irq_enable_reg;
  reg        ch0_done_irq_enable_next;
  reg        ch1_done_irq_enable_reg;
  reg        ch1_done_irq_enable_next;
  reg        dma_master_enable_reg;
  reg        dma_master_enable_next;
  reg  [7:0] mode_reg;
  reg  [7:0] mode_next;
  reg  [7:0] rdata_next;

  wire       wr_status;
  wire       wr_mode;
  wire       ch0_guard_open;
  wire       ch1_guard_open;
  wire       ch0_set;
  wire       ch1_set;
  wire [1:0] ch0_dest_mode;
  wire [1:0] ch0_src_mode;
  wire       mem_transfer_timing;
  wire       ch0_io_mode;
  wire [7:0] status_view;

  assign wr_status = WR_IN && (ADDR_IN == `DMC_ADDR_STATUS);
  assign wr_mode   = WR_IN && (ADDR_IN == `DMC_ADDR_MODE);

  // Guard bit written as zero opens the enable bit
  assign ch0_guard_open = wr_status && !WDATA_IN[`DMC_ST_CH0_GUARD];
  assign ch1_guard_open = wr_status && !WDATA_IN[`DMC_ST_CH1_GUARD];
  assign ch0_set = ch0_guard_open && WDATA_IN[`DMC_ST_CH0_EN];
  assign ch1_set = ch1_guard_open && WDATA_IN[`DMC_ST_CH1_EN];

  assign ch0_dest_mode       = mode_reg[`DMC_MD_DST_HI:`DMC_MD_DST_LO];
  assign ch0_src_mode        = mode_reg[`DMC_MD_SRC_HI:`DMC_MD_SRC_LO];
  assign mem_transfer_timing = mode_reg[`DMC_MD_TIMING];

  // ----------------------------------------
  // Enable bits
  // ----------------------------------------
  // A software write wins over a same-cycle count-zero clear,
  // since rewriting one is how software restarts the channel.
  always @* begin
    ch0_enable_next = ch0_enable_reg;
    if (CH0_COUNT_ZERO_IN) begin
      ch0_enable_next = 1'b0;
    end
    if (ch0_guard_open) begin
      ch0_enable_next = WDATA_IN[`DMC_ST_CH0_EN];
    end
  end

  always @* begin
    ch1_enable_next = ch1_enable_reg;
    if (CH1_COUNT_ZERO_IN) begin
      ch1_enable_next = 1'b0;
    end
    if (ch1_guard_open) begin
      ch1_enable_next = WDATA_IN[`DMC_ST_CH1_EN];
    end
  end

  // ----------------------------------------
  // Master enable
  // ----------------------------------------
  // Not directly writable. Enable write beats NMI in the same cycle,
  // so a resume is never lost.
  always @* begin
    dma_master_enable_next = dma_master_enable_reg;
    if (NMI_IN) begin
      dma_master_enable_next = 1'b0;
    end
    if (ch0_set || ch1_set) begin
      dma_master_enable_next = 1'b1;
    end
  end

  // ----------------------------------------
  // Interrupt enables and mode register
  // ----------------------------------------
  always @* begin
    ch0_done_irq_enable_next = ch0_done_irq_enable_reg;
    ch1_done_irq_enable_next = ch1_done_irq_enable_reg;
    if (wr_status) begin
      ch0_done_irq_enable_next = WDATA_IN[`DMC_ST_CH0_IE];
      ch1_done_irq_enable_next = WDATA_IN[`DMC_ST_CH1_IE];
    end
  end

  always @* begin
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = WDATA_IN & `DMC_MODE_MASK;
    end
  end

  always @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ch0_enable_reg          <= 1'b0;
      ch1_enable_reg          <= 1'b0;
      ch0_done_irq_enable_reg <= 1'b0;
      ch1_done_irq_enable_reg <= 1'b0;
      dma_master_enable_reg   <= 1'b0;
      mode_reg                <= `DMC_MODE_RESET;
      RDATA_OUT               <= 8'h00;
    end else begin
      ch0_enable_reg          <= ch0_enable_next;
      ch1_enable_reg          <= ch1_enable_next;
      ch0_done_irq_enable_reg <= ch0_done_irq_enable_next;
      ch1_done_irq_enable_reg <= ch1_done_irq_enable_next;
      dma_master_enable_reg   <= dma_master_enable_next;
      mode_reg                <= mode_next;
      RDATA_OUT               <= rdata_next;
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Guard bits hold nothing; unused bit 1 reads zero
  assign status_view = {ch1_enable_reg, ch0_enable_reg, 1'b1, 1'b1,
                        ch1_done_irq_enable_reg, ch0_done_irq_enable_reg,
                        1'b0, dma_master_enable_reg};

  always @* begin
    rdata_next = RDATA_OUT;
    if (RD_IN) begin
      case (ADDR_IN)
        `DMC_ADDR_STATUS: rdata_next = status_view;
        `DMC_ADDR_MODE:   rdata_next = mode_reg;
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Channel activity and interrupts
  // ----------------------------------------
  assign CH0_ACTIVE_OUT = ch0_enable_reg && dma_master_enable_reg;
  assign CH1_ACTIVE_OUT = ch1_enable_reg && dma_master_enable_reg;

  // Levels, held until software re-enables or masks
  assign CH0_IRQ_OUT = !ch0_enable_reg && ch0_done_irq_enable_reg;
  assign CH1_IRQ_OUT = !ch1_enable_reg && ch1_done_irq_enable_reg;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  dmc_mode_decode u_src_decode (
    .mode_in   (ch0_src_mode),
    .is_io_out (CH0_SRC_IO_OUT),
    .inc_out   (CH0_SRC_INC_OUT),
    .dec_out   (CH0_SRC_DEC_OUT)
  );

  dmc_mode_decode u_dst_decode (
    .mode_in   (ch0_dest_mode),
    .is_io_out (CH0_DST_IO_OUT),
    .inc_out   (CH0_DST_INC_OUT),
    .dec_out   (CH0_DST_DEC_OUT)
  );

  // Reserved codes: fixed-memory or I/O destination with fixed/I/O source
  assign CH0_MODE_VALID_OUT = !(ch0_dest_mode[1] && ch0_src_mode[1]);

  assign ch0_io_mode = CH0_SRC_IO_OUT || CH0_DST_IO_OUT;

  // ----------------------------------------
  // Pacing
  // ----------------------------------------
  // Reserved modes never start a transfer
  dmc_pace u_pace (
    .clk_in       (CLK_IN),
    .rstn_in      (RSTN_IN),
    .active_in    (CH0_ACTIVE_OUT && CH0_MODE_VALID_OUT),
    .io_mode_in   (ch0_io_mode),
    .burst_in     (mem_transfer_timing),
    .request_in   (CH0_REQUEST_IN),
    .xfer_in      (CH0_XFER_DONE_IN),
    .go_out       (CH0_GO_OUT),
    .bus_hold_out (CH0_BUS_HOLD_OUT)
  );

endmodule // dmc_top

/* File: tb/dmc_top_checker.sv */
// Port assertions for dmc_top.
// Assumes the bind below attaches it to every dmc_top.
module dmc_top_checker (
  input wire       CLK_IN,
  input wire       RSTN_IN,
  input wire [7:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire       WR_IN,
  input wire       RD_IN,
  input wire       NMI_IN,
  input wire       CH0_COUNT_ZERO_IN,
  input wire       CH0_XFER_DONE_IN,
  input wire [7:0] RDATA_OUT,
  input wire       CH0_ACTIVE_OUT,
  input wire       CH1_ACTIVE_OUT,
  input wire       CH0_GO_OUT,
  input wire       CH0_BUS_HOLD_OUT,
  input wire       CH0_IRQ_OUT,
  input wire       CH0_SRC_IO_OUT,
  input wire       CH0_DST_IO_OUT,
  input wire       CH0_MODE_VALID_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  wire st_wr = WR_IN && ADDR_IN == 8'h30;
  wire st_rd = RD_IN && ADDR_IN == 8'h30;
  wire mem   = !CH0_SRC_IO_OUT && !CH0_DST_IO_OUT;
  a_zero_clears: assert property (CH0_COUNT_ZERO_IN && !st_wr |=> !CH0_ACTIVE_OUT)
    else $error("count zero left channel 0 active");
  a_guard_holds: assert property (st_wr && WDATA_IN[5:4] == 2'b11 && !NMI_IN
    && !CH0_COUNT_ZERO_IN |=> CH0_ACTIVE_OUT == $past(CH0_ACTIVE_OUT))
    else $error("guarded write changed channel 0");
  a_enable_sets: assert property (st_wr && WDATA_IN[6:4] == 3'b100 |=> CH0_ACTIVE_OUT)
    else $error("enable write did not activate channel 0");
  a_nmi_halts: assert property (NMI_IN && !st_wr |=> !CH0_ACTIVE_OUT && !CH1_ACTIVE_OUT)
    else $error("nmi left a channel active");
  a_guard_reads: assert property (st_rd |=> RDATA_OUT[5:4] == 2'b11)
    else $error("guard bits not read as one");
  a_irq_level: assert property (st_rd && !WR_IN && !CH0_COUNT_ZERO_IN
    |=> CH0_IRQ_OUT == (!RDATA_OUT[6] && RDATA_OUT[2]))
    else $error("channel 0 irq disagrees with status");
  a_go_active: assert property (CH0_GO_OUT |-> CH0_ACTIVE_OUT)
    else $error("go while channel 0 inactive");
  a_burst_holds: assert property (CH0_BUS_HOLD_OUT |-> CH0_GO_OUT && mem)
    else $error("burst hold without go");
  a_steal_gap: assert property (CH0_XFER_DONE_IN && CH0_GO_OUT && mem && !WR_IN
    && !CH0_BUS_HOLD_OUT |=> !CH0_GO_OUT)
    else $error("cycle steal gave no cpu cycle");
  a_reserved_idle: assert property (!CH0_MODE_VALID_OUT |-> !CH0_GO_OUT)
    else $error("go in reserved mode");
endmodule // dmc_top_checker

bind dmc_top dmc_top_checker dmc_top_checker_inst (.*);

/* File: tb/dmc_bus_model.sv */
// Far-side model: external request source and transfer completion.
// Assumes go_in is the block's grant, sampled on the rising edge.
module dmc_bus_model (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic go_in,
  input  wire logic req_en_in,
  input  wire logic slow_in,
  output logic      request_out,
  output logic      done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wait_reg;
  assign request_out = req_en_in;
  // One-cycle completion pulse while granted, never on consecutive cycles; slow inserts a wait first
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_out <= 1'b0;
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= slow_in && go_in && !wait_reg && !done_out;
      done_out <= go_in && !done_out && (wait_reg || !slow_in);
    end
  end
endmodule // dmc_bus_model

/* File: tb/dmc_top_test.sv */
// Self-checking bench for dmc_top.
// Assumes the checker and bus model files are compiled first.
module dmc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, nmi = 0, cz0 = 0, cz1 = 0, req_en = 0, slow = 0;
  logic req, done, act0, act1, go, hold, irq0, irq1, valid;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [5:0] dec;
  int error_cnt = 0, checks = 0;
  dmc_top dmc_top_inst (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .NMI_IN(nmi), .CH0_COUNT_ZERO_IN(cz0), .CH1_COUNT_ZERO_IN(cz1),
    .CH0_REQUEST_IN(req), .CH0_XFER_DONE_IN(done), .RDATA_OUT(rdata), .CH0_ACTIVE_OUT(act0),
    .CH1_ACTIVE_OUT(act1), .CH0_GO_OUT(go), .CH0_BUS_HOLD_OUT(hold), .CH0_IRQ_OUT(irq0),
    .CH1_IRQ_OUT(irq1), .CH0_SRC_IO_OUT(dec[5]), .CH0_SRC_INC_OUT(dec[4]),
    .CH0_SRC_DEC_OUT(dec[3]), .CH0_DST_IO_OUT(dec[2]), .CH0_DST_INC_OUT(dec[1]),
    .CH0_DST_DEC_OUT(dec[0]), .CH0_MODE_VALID_OUT(valid));
  dmc_bus_model dmc_bus_model_inst (.clk_in(clk), .rstn_in(rstn), .go_in(go),
    .req_en_in(req_en), .slow_in(slow), .request_out(req), .done_out(done));
  always #25 clk = ~clk;
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    cyc();
    wr = 0;
    // Idle edge so back-to-back writes never re-raise the strobe at once
    cyc();
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp, string name);
    addr = a;
    rd = 1;
    cyc();
    rd = 0;
    chk(name, exp, rdata);
    cyc();
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_reset;
    chk("outs", 8'h00, {2'b00, irq0, irq1, act0, act1, go, hold});
    rd_chk(8'h30, 8'h30, "status");
    rd_chk(8'h31, 8'h00, "mode");
    rd_chk(8'h3f, 8'h00, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_guard;
    wr_reg(8'h30, 8'h44);
    rd_chk(8'h30, 8'h75, "enable");
    wr_reg(8'h30, 8'h30);
    rd_chk(8'h30, 8'h71, "guarded");
    wr_reg(8'h30, 8'h20);
    rd_chk(8'h30, 8'h31, "stop");
    $display("guard test done");
  endtask
  task automatic t_irq;
    wr_reg(8'h30, 8'h3c);
    cyc(3);
    chk("irq both", 8'h03, {6'd0, irq0, irq1});
    wr_reg(8'h30, 8'h98);
    chk("ch1 on", 8'h01, {5'd0, irq0, irq1, act1});
    cz1 = 1;
    cyc();
    cz1 = 0;
    chk("ch1 end", 8'h02, {6'd0, irq1, act1});
    wr_reg(8'h30, 8'h30);
    chk("irq off", 8'h00, {7'd0, irq1});
    $display("irq test done");
  endtask
  task automatic t_nmi;
    wr_reg(8'h30, 8'hc0);
    chk("both on", 8'h03, {6'd0, act0, act1});
    nmi = 1;
    cyc();
    nmi = 0;
    chk("halted", 8'h00, {6'd0, act0, act1});
    rd_chk(8'h30, 8'hf0, "nmi status");
    wr_reg(8'h30, 8'hf0);
    chk("no resume", 8'h00, {6'd0, act0, act1});
    wr_reg(8'h30, 8'hc0);
    chk("resumed", 8'h03, {6'd0, act0, act1});
    cz0 = 1;
    cyc();
    cz0 = 0;
    chk("ch0 end", 8'h01, {6'd0, act0, act1});
    rd_chk(8'h30, 8'hb1, "end status");
    wr_reg(8'h30, 8'h60);
    $display("halt test done");
  endtask
  task automatic t_modes;
    logic [1:0] d, s;
    for (int m = 0; m < 16; m++) begin
      d = m[3:2];
      s = m[1:0];
      wr_reg(8'h31, {2'b11, d, s, 2'b11});
      rd_chk(8'h31, {2'b00, d, s, 2'b10}, "mode");
      chk("decode", {2'b00, s == 3, s == 0, s == 1, d == 3, d == 0, d == 1}, dec);
      chk("valid", {7'd0, !(d[1] && s[1])}, {7'd0, valid});
    end
    $display("mode test done");
  endtask
  task automatic t_pace;
    wr_reg(8'h31, 8'h02);
    for (int i = 0; i < 4; i++) begin
      chk("burst", 8'h03, {6'd0, go, hold});
      cyc();
    end
    slow = 1;
    wr_reg(8'h31, 8'h00);
    for (int i = 0; i < 10 && done !== 1'b1; i++) cyc();
    cyc();
    chk("steal gap", 8'h00, {7'd0, go});
    cyc();
    chk("steal go", 8'h01, {7'd0, go});
    wr_reg(8'h31, 8'h0c);
    chk("io idle", 8'h00, {7'd0, go});
    req_en = 1;
    wr_reg(8'h31, 8'h0e);
    chk("io paced", 8'h02, {6'd0, go, hold});
    wr_reg(8'h31, 8'h28);
    chk("reserved", 8'h00, {7'd0, go});
    $display("pacing test done");
  endtask
  initial begin
    cyc(6);
    rstn = 1;
    t_reset();
    t_guard();
    t_irq();
    t_nmi();
    t_modes();
    t_pace();
    tally_and_finish();
  end
  initial begin
    #200us;
    error_cnt++;
    $display("Watchdog expired");
    tally_and_finish();
  end
endmodule // dmc_top_test
